/* File: eag_pkg.sv */
// shared constants, types and carriers for the effective address generator
// assumes a single core clock and requests from decoder logic on that clock
package eag_pkg;

    localparam int XLEN = 32;
    localparam int GPR_COUNT = 8;
    localparam int SEL_W = 3;
    localparam int NUM_MODES = 11;
    localparam int EXTRA_CLOCKS = 1;
    localparam logic [SEL_W-1:0] STACK_POINTER_REG = 3'h4;
    localparam logic [XLEN-1:0] ADDR16_MASK = 32'h0000ffff;
    localparam logic [XLEN-1:0] RESET_WORD = 32'h00000000;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;
    localparam int BYTE_HI_SEL = 4;

    typedef enum logic [3:0] {
        MODE_REG,
        MODE_IMM,
        MODE_DIRECT,
        MODE_REG_INDIRECT,
        MODE_BASED,
        MODE_INDEX,
        MODE_SCALED_INDEX,
        MODE_BASED_INDEX,
        MODE_BASED_SCALED_INDEX,
        MODE_BASED_INDEX_DISP,
        MODE_BASED_SCALED_INDEX_DISP
    } eag_mode_t;

    typedef enum logic [1:0] {
        DISP_NONE,
        DISP_BYTE,
        DISP_WORD,
        DISP_DWORD
    } eag_disp_size_t;

    typedef enum logic [1:0] {
        WIDTH_8,
        WIDTH_16,
        WIDTH_32
    } eag_width_t;

    typedef enum logic [1:0] {
        ERR_NONE,
        ERR_SP_INDEX,
        ERR_BAD_DISP,
        ERR_BAD_MODE
    } eag_err_t;

    typedef enum logic {
        PH_RUN,
        PH_EXTRA
    } eag_phase_t;

    typedef struct packed {
        eag_mode_t mode;
        logic [SEL_W-1:0] base_sel;
        logic [SEL_W-1:0] index_sel;
        logic [1:0] scale_code;
        eag_disp_size_t disp_size;
        logic [XLEN-1:0] disp;
        logic [XLEN-1:0] imm;
        logic [XLEN-1:0] seg_base;
        logic code_size_flag;
        logic addr_size_pfx;
        logic opnd_size_pfx;
        logic byte_op;
    } eag_req_t;

    typedef struct packed {
        logic is_mem;
        eag_width_t width;
        logic addr16;
        logic [XLEN-1:0] operand;
        logic [XLEN-1:0] effective_addr;
        logic [XLEN-1:0] linear;
    } eag_resp_t;

endpackage : eag_pkg

/* File: eag_sum3.sv */
// three-operand wrapping adder for the offset path
// assumes operands already sign-extended and scaled by the caller
`timescale 1ns/1ps
module eag_sum3
    import eag_pkg::*;
(
    // operands
    input wire logic [XLEN-1:0] a_i,
    input wire logic [XLEN-1:0] b_i,
    input wire logic [XLEN-1:0] c_i,
    // 16-bit address size wraps at 64k
    input wire logic addr16_i,
    // result
    output logic [XLEN-1:0] sum_o
);

    logic [XLEN-1:0] raw;

    always_comb begin
        raw = XLEN'(a_i + b_i + c_i);
        sum_o = addr16_i ? (raw & ADDR16_MASK) : raw;
    end

endmodule : eag_sum3

/* File: eag_core.sv */
// operand addressing and linear address generation
// assumes decoder and register file run on clk_i; gpr_i is sampled when a request is taken
`timescale 1ns/1ps
module eag_core
    import eag_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // request from the decoder
    input wire logic req_valid_i,
    input wire eag_req_t req_i,
    output logic ready_o,
    // register file contents
    input wire logic [GPR_COUNT-1:0][XLEN-1:0] gpr_i,
    // answer to the segmentation unit
    output logic resp_valid_o,
    output eag_resp_t resp_o,
    output logic err_o,
    output eag_err_t err_code_o
);

    typedef struct packed {
        eag_phase_t phase;
        logic ready;
        logic valid;
        logic err;
        eag_err_t err_code;
        eag_resp_t resp;
        logic [XLEN-1:0] partial;
        logic [XLEN-1:0] pend_disp;
        logic [XLEN-1:0] pend_seg;
        logic pend_addr16;
        eag_width_t pend_width;
    } eag_state_t;

    eag_state_t state_r;
    eag_state_t state_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;

    // decode terms
    logic addr16;
    logic opnd16;
    eag_width_t width;
    logic [XLEN-1:0] base_val;
    logic [XLEN-1:0] index_val;
    logic [XLEN-1:0] index_scaled;
    logic [XLEN-1:0] disp_ext;
    logic [XLEN-1:0] reg_operand;
    logic [XLEN-1:0] imm_operand;
    logic [XLEN-1:0] width_mask;
    logic [SEL_W-1:0] byte_reg;
    logic is_mem;
    logic bad_index;
    logic bad_disp;
    logic bad_mode;
    logic combined;

    // adder hookup
    logic [XLEN-1:0] add_a;
    logic [XLEN-1:0] add_b;
    logic [XLEN-1:0] add_c;
    logic add_addr16;
    logic [XLEN-1:0] add_sum;

    // reset release through two flops so every state flop leaves reset on one edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_r <= RST_SYNC_RESET;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    eag_sum3 u_sum3 (
        .a_i(add_a),
        .b_i(add_b),
        .c_i(add_c),
        .addr16_i(add_addr16),
        .sum_o(add_sum)
    );

    always_comb begin
        addr16 = ~(req_i.code_size_flag ^ req_i.addr_size_pfx);
        opnd16 = ~(req_i.code_size_flag ^ req_i.opnd_size_pfx);
        if (req_i.byte_op) begin
            width = WIDTH_8;
        end else if (opnd16) begin
            width = WIDTH_16;
        end else begin
            width = WIDTH_32;
        end
        unique case (width)
            WIDTH_8: width_mask = 32'h000000ff;
            WIDTH_16: width_mask = 32'h0000ffff;
            default: width_mask = 32'hffffffff;
        endcase
        base_val = gpr_i[req_i.base_sel];
        index_val = gpr_i[req_i.index_sel];
        index_scaled = XLEN'(index_val << req_i.scale_code);
        unique case (req_i.disp_size)
            DISP_NONE: disp_ext = RESET_WORD;
            DISP_BYTE: disp_ext = {{24{req_i.disp[7]}}, req_i.disp[7:0]};
            DISP_WORD: disp_ext = {{16{req_i.disp[15]}}, req_i.disp[15:0]};
            DISP_DWORD: disp_ext = req_i.disp;
        endcase
        // byte registers four and up are high bytes
        byte_reg = req_i.base_sel & 3'h3;
        if (req_i.byte_op && (int'(req_i.base_sel) >= BYTE_HI_SEL)) begin
            reg_operand = {24'h000000, gpr_i[byte_reg][15:8]};
        end else begin
            reg_operand = gpr_i[req_i.base_sel] & width_mask;
        end
        imm_operand = req_i.imm & width_mask;
        is_mem = (req_i.mode != MODE_REG) && (req_i.mode != MODE_IMM);
        unique case (req_i.mode)
            MODE_INDEX, MODE_SCALED_INDEX, MODE_BASED_INDEX, MODE_BASED_SCALED_INDEX,
            MODE_BASED_INDEX_DISP, MODE_BASED_SCALED_INDEX_DISP:
                bad_index = (req_i.index_sel == STACK_POINTER_REG);
            default: bad_index = 1'b0;
        endcase
        // word displacement only for direct or 16-bit addressing
        bad_disp = is_mem && !addr16 && (req_i.disp_size == DISP_WORD) && (req_i.mode != MODE_DIRECT);
        // only the eleven modes are legal
        bad_mode = (int'(req_i.mode) >= NUM_MODES);
        unique case (req_i.mode)
            MODE_BASED_INDEX, MODE_BASED_SCALED_INDEX, MODE_BASED_INDEX_DISP,
            MODE_BASED_SCALED_INDEX_DISP:
                combined = 1'b1;
            default: combined = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.valid = 1'b0;
        state_nxt.err = 1'b0;
        state_nxt.err_code = ERR_NONE;
        add_a = RESET_WORD;
        add_b = RESET_WORD;
        add_c = RESET_WORD;
        add_addr16 = 1'b0;
        unique case (state_r.phase)
            PH_RUN: begin
                if (req_valid_i && state_r.ready) begin
                    // offset operands per mode, absent parts zero
                    unique case (req_i.mode)
                        MODE_DIRECT: begin
                            add_a = disp_ext;
                        end
                        MODE_REG_INDIRECT: begin
                            add_a = base_val;
                        end
                        MODE_BASED: begin
                            add_a = base_val;
                            add_b = disp_ext;
                        end
                        MODE_INDEX: begin
                            add_a = index_val;
                            add_b = disp_ext;
                        end
                        MODE_SCALED_INDEX: begin
                            add_a = index_scaled;
                            add_b = disp_ext;
                        end
                        MODE_BASED_INDEX, MODE_BASED_INDEX_DISP: begin
                            add_a = base_val;
                            add_b = index_val;
                        end
                        MODE_BASED_SCALED_INDEX, MODE_BASED_SCALED_INDEX_DISP: begin
                            add_a = base_val;
                            add_b = index_scaled;
                        end
                        default: begin
                            add_a = RESET_WORD;
                        end
                    endcase
                    add_addr16 = addr16 && !combined;
                    if (bad_mode || bad_index || bad_disp) begin
                        state_nxt.err = 1'b1;
                        if (bad_mode) begin
                            state_nxt.err_code = ERR_BAD_MODE;
                        end else if (bad_index) begin
                            state_nxt.err_code = ERR_SP_INDEX;
                        end else begin
                            state_nxt.err_code = ERR_BAD_DISP;
                        end
                    end else if (!is_mem) begin
                        state_nxt.valid = 1'b1;
                        state_nxt.resp.is_mem = 1'b0;
                        state_nxt.resp.width = width;
                        state_nxt.resp.addr16 = addr16;
                        state_nxt.resp.effective_addr = RESET_WORD;
                        state_nxt.resp.linear = RESET_WORD;
                        if (req_i.mode == MODE_REG) begin
                            state_nxt.resp.operand = reg_operand;
                        end else begin
                            state_nxt.resp.operand = imm_operand;
                        end
                    end else if (combined) begin
                        // hold partial sum one extra clock
                        state_nxt.phase = PH_EXTRA;
                        state_nxt.ready = 1'b0;
                        state_nxt.partial = add_sum;
                        if ((req_i.mode == MODE_BASED_INDEX_DISP) || (req_i.mode == MODE_BASED_SCALED_INDEX_DISP)) begin
                            state_nxt.pend_disp = disp_ext;
                        end else begin
                            state_nxt.pend_disp = RESET_WORD;
                        end
                        state_nxt.pend_seg = req_i.seg_base;
                        state_nxt.pend_addr16 = addr16;
                        state_nxt.pend_width = width;
                    end else begin
                        state_nxt.valid = 1'b1;
                        state_nxt.resp.is_mem = 1'b1;
                        state_nxt.resp.width = width;
                        state_nxt.resp.addr16 = addr16;
                        state_nxt.resp.operand = RESET_WORD;
                        state_nxt.resp.effective_addr = add_sum;
                        state_nxt.resp.linear = XLEN'(req_i.seg_base + add_sum);
                    end
                end
            end
            PH_EXTRA: begin
                // partial plus displacement completes the sum
                add_a = state_r.partial;
                add_b = state_r.pend_disp;
                add_addr16 = state_r.pend_addr16;
                state_nxt.phase = PH_RUN;
                state_nxt.ready = 1'b1;
                state_nxt.valid = 1'b1;
                state_nxt.resp.is_mem = 1'b1;
                state_nxt.resp.width = state_r.pend_width;
                state_nxt.resp.addr16 = state_r.pend_addr16;
                state_nxt.resp.operand = RESET_WORD;
                state_nxt.resp.effective_addr = add_sum;
                state_nxt.resp.linear = XLEN'(state_r.pend_seg + add_sum);
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r.phase <= PH_RUN;
            state_r.ready <= 1'b0;
            state_r.valid <= 1'b0;
            state_r.err <= 1'b0;
            state_r.err_code <= ERR_NONE;
            state_r.resp <= '0;
            state_r.partial <= RESET_WORD;
            state_r.pend_disp <= RESET_WORD;
            state_r.pend_seg <= RESET_WORD;
            state_r.pend_addr16 <= 1'b0;
            state_r.pend_width <= WIDTH_32;
        end else begin
            state_r <= state_nxt;
            // ready rises on the first edge after reset release
            if (state_r.phase == PH_RUN) begin
                state_r.ready <= 1'b1;
            end
            if (state_nxt.phase == PH_EXTRA) begin
                state_r.ready <= 1'b0;
            end
        end
    end

    assign ready_o = state_r.ready;
    assign resp_valid_o = state_r.valid;
    assign resp_o = state_r.resp;
    assign err_o = state_r.err;
    assign err_code_o = state_r.err_code;

endmodule : eag_core

/* File: eag_rf_model.sv */
// register file model feeding the generator's gpr_i
// assumes contents are static for the run
`timescale 1ns/1ps
module eag_rf_model
    import eag_pkg::*;
(
    // register contents
    output logic [GPR_COUNT-1:0][XLEN-1:0] gpr_o
);
    // every slot distinct
    // large values so that sums wrap past bit 31
    always_comb begin
        for (int i = 0; i < GPR_COUNT; i++) begin
            gpr_o[i] = XLEN'(32'h9e3779b9 * (i + 1));
        end
    end
endmodule : eag_rf_model

/* File: eag_chk.sv */
// timing and refusal checks on eag_core ports
// assumes one core clock; rstn_i low disables all checks
`timescale 1ns/1ps
module eag_chk
    import eag_pkg::*;
(
    // watched ports
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    input wire eag_req_t req_i,
    input wire logic ready_o,
    input wire logic [GPR_COUNT-1:0][XLEN-1:0] gpr_i,
    input wire logic resp_valid_o,
    input wire eag_resp_t resp_o,
    input wire logic err_o,
    input wire eag_err_t err_code_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic tk, a32, badm, spx, cmb, bad;
    logic [XLEN-1:0] bval;
    assign tk = req_valid_i && ready_o;
    assign a32 = req_i.code_size_flag ^ req_i.addr_size_pfx;
    assign badm = req_i.mode > MODE_BASED_SCALED_INDEX_DISP;
    assign spx = !badm && req_i.mode >= MODE_INDEX && req_i.index_sel == STACK_POINTER_REG;
    assign cmb = !badm && req_i.mode >= MODE_BASED_INDEX;
    assign bad = badm || spx || (a32 && req_i.disp_size == DISP_WORD && req_i.mode != MODE_DIRECT);
    assign bval = gpr_i[req_i.base_sel];

    a_bad_mode: assert property (tk && badm |=> err_o && err_code_o == ERR_BAD_MODE)
        else $error("unknown mode not refused");
    a_sp_index: assert property (tk && spx |=> err_o && err_code_o == ERR_SP_INDEX)
        else $error("stack pointer index not refused");
    a_bad_disp: assert property (tk && bad && !badm && !spx |=> err_o && err_code_o == ERR_BAD_DISP)
        else $error("word displacement not refused");
    a_simple_lat: assert property (tk && !bad && !cmb |=> resp_valid_o && ready_o && !err_o)
        else $error("simple mode answer late");
    a_extra_clock: assert property (tk && !bad && cmb |=> !ready_o && !resp_valid_o ##1 resp_valid_o && ready_o)
        else $error("combined mode timing wrong");
    a_direct_off: assert property (tk && !bad && a32 && req_i.mode == MODE_DIRECT && req_i.disp_size == DISP_DWORD
        |=> resp_o.effective_addr == $past(req_i.disp) && resp_o.linear == $past(req_i.disp) + $past(req_i.seg_base))
        else $error("direct offset wrong");
    a_reg_indirect: assert property (tk && !bad && a32 && req_i.mode == MODE_REG_INDIRECT
        |=> resp_o.effective_addr == $past(bval))
        else $error("register indirect offset wrong");
    a_one_answer: assert property (!(resp_valid_o && err_o))
        else $error("answer and refusal together");
    a_err_idle: assert property (!err_o |-> err_code_o == ERR_NONE)
        else $error("error code without error");

    c_combined: cover property (tk && !bad && cmb);
    c_refused: cover property (err_o);
    c_back2back: cover property (resp_valid_o [*2]);
endmodule : eag_chk

bind eag_core eag_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .ready_o(ready_o), .gpr_i(gpr_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o), .err_o(err_o),
    .err_code_o(err_code_o));

/* File: testbench.sv */
// self-checking bench for eag_core
// assumes register file model supplies gpr_i
`timescale 1ns/1ps
module testbench
    import eag_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic req_valid_i = 1'b0;
    eag_req_t req_i = '0;
    logic [GPR_COUNT-1:0][XLEN-1:0] gpr;
    logic ready_o, resp_valid_o, err_o;
    eag_resp_t resp_o;
    eag_err_t err_code_o;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;

    eag_rf_model u_rf (.gpr_o(gpr));
    eag_core uut (.clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o),
        .gpr_i(gpr), .resp_valid_o(resp_valid_o), .resp_o(resp_o), .err_o(err_o), .err_code_o(err_code_o));

    task automatic chk(input logic [XLEN-1:0] got, input logic [XLEN-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic eag_req_t mk(input eag_mode_t m, input eag_disp_size_t ds, input logic [XLEN-1:0] d);
        eag_req_t r;
        r = '0;
        r.mode = m;
        r.disp_size = ds;
        r.disp = d;
        r.base_sel = 3'h1;
        r.index_sel = 3'h2;
        r.scale_code = 2'h3;
        r.seg_base = 32'h00123400;
        r.code_size_flag = 1'b1;
        return r;
    endfunction : mk

    function automatic logic [XLEN-1:0] eoff(input eag_req_t r);
        logic [XLEN-1:0] b, x, s, d, o;
        b = gpr[r.base_sel];
        x = gpr[r.index_sel];
        s = x << r.scale_code;
        case (r.disp_size)
            DISP_BYTE: d = {{24{r.disp[7]}}, r.disp[7:0]};
            DISP_WORD: d = {{16{r.disp[15]}}, r.disp[15:0]};
            DISP_DWORD: d = r.disp;
            default: d = '0;
        endcase
        case (r.mode)
            MODE_DIRECT: o = d;
            MODE_REG_INDIRECT: o = b;
            MODE_BASED: o = b + d;
            MODE_INDEX: o = x + d;
            MODE_SCALED_INDEX: o = s + d;
            MODE_BASED_INDEX: o = b + x;
            MODE_BASED_SCALED_INDEX: o = b + s;
            MODE_BASED_INDEX_DISP: o = b + x + d;
            default: o = b + s + d;
        endcase
        // 16-bit addressing keeps only the low 64k of the offset
        if (!(r.code_size_flag ^ r.addr_size_pfx)) o = o & ADDR16_MASK;
        return o;
    endfunction : eoff

    // one request, answer latency lat; exp is offset, operand or error code
    task automatic run(input eag_req_t r, input int lat, input logic [XLEN-1:0] exp);
        int n;
        n = 0;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        do begin
            @(negedge clk_i);
            n++;
        end while (!(resp_valid_o === 1'b1 || err_o === 1'b1) && n < 4);
        chk(XLEN'(n), XLEN'(lat));
        if (err_o === 1'b1) begin
            chk(XLEN'(err_code_o), exp);
        end else if (resp_o.is_mem === 1'b1) begin
            chk(resp_o.effective_addr, exp);
            chk(resp_o.linear, exp + r.seg_base);
        end else begin
            chk(resp_o.operand, exp);
        end
    endtask : run

    task automatic t_modes;
        eag_req_t r;
        for (int k = 0; k < 2; k++) begin
            for (int m = 2; m < NUM_MODES; m++) begin
                r = mk(eag_mode_t'(m), k ? DISP_DWORD : DISP_BYTE, 32'h876543f0);
                run(r, (m >= 7) ? 2 : 1, eoff(r));
            end
        end
        $display("t_modes done");
    endtask : t_modes

    task automatic t_base;
        eag_req_t r;
        for (int i = 0; i < GPR_COUNT; i++) begin
            r = mk(MODE_REG_INDIRECT, DISP_NONE, '0);
            r.base_sel = SEL_W'(i);
            run(r, 1, gpr[i]);
        end
        $display("t_base done");
    endtask : t_base

    task automatic t_refuse;
        eag_req_t r;
        r = mk(MODE_BASED_SCALED_INDEX_DISP, DISP_BYTE, 32'h10);
        r.index_sel = STACK_POINTER_REG;
        run(r, 1, XLEN'(ERR_SP_INDEX));
        r = mk(MODE_BASED, DISP_WORD, 32'h1234);
        run(r, 1, XLEN'(ERR_BAD_DISP));
        r.mode = eag_mode_t'(4'hb);
        run(r, 1, XLEN'(ERR_BAD_MODE));
        $display("t_refuse done");
    endtask : t_refuse

    task automatic t_reg_imm;
        eag_req_t r;
        r = mk(MODE_REG, DISP_NONE, '0);
        r.base_sel = 3'h3;
        run(r, 1, gpr[3]);
        r.byte_op = 1'b1;
        r.base_sel = 3'h5;
        run(r, 1, {24'h0, gpr[1][15:8]});
        r = mk(MODE_IMM, DISP_NONE, '0);
        r.imm = 32'hcafe1234;
        run(r, 1, 32'hcafe1234);
        $display("t_reg_imm done");
    endtask : t_reg_imm

    task automatic t_addr16;
        eag_req_t r;
        r = mk(MODE_BASED, DISP_WORD, 32'h0000f00d);
        r.code_size_flag = 1'b0;
        run(r, 1, eoff(r));
        r = mk(MODE_BASED_INDEX_DISP, DISP_DWORD, 32'h00fffff0);
        r.code_size_flag = 1'b0;
        r.addr_size_pfx = 1'b1;
        run(r, 2, eoff(r));
        $display("t_addr16 done");
    endtask : t_addr16

    task automatic t_b2b;
        eag_req_t r1, r2;
        r1 = mk(MODE_BASED, DISP_BYTE, 32'h7f);
        r2 = mk(MODE_SCALED_INDEX, DISP_DWORD, 32'h11);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= r1;
        @(posedge clk_i);
        req_i <= r2;
        @(negedge clk_i);
        chk({31'h0, resp_valid_o}, 32'h1);
        chk(resp_o.effective_addr, eoff(r1));
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, resp_valid_o}, 32'h1);
        chk(resp_o.effective_addr, eoff(r2));
        $display("t_b2b done");
    endtask : t_b2b

    task automatic complete_run;
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_modes;
        t_base;
        t_refuse;
        t_reg_imm;
        t_addr16;
        t_b2b;
        complete_run;
    end

    // whole run needs well under 200 cycles
    initial begin
        #20000;
        n_mismatch++;
        complete_run;
    end
endmodule : testbench
